// >>> verilog/eqsr_top.sv
// Error queue, trajectory mode store and status reporter behind an AXI4-Lite slave.
// Assumes axis motion, power, group and position inputs are synchronous to sys_clk.
//
// Local design decisions: the address map and register access over AXI4-Lite.
`timescale 1ns/1ns

module eqsr_top #(
    parameter int TICK_LEN = eqsr_pkg::TICK_CYCLES
) (
    input  wire logic                  sys_clk,
    input  wire logic                  rst,
    input  wire logic [7:0]            s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [7:0]            s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    input  wire logic [eqsr_pkg::NUM_AXES-1:0] axisMoving,
    input  wire logic [eqsr_pkg::NUM_AXES-1:0] axisPowered,
    input  wire logic [eqsr_pkg::NUM_AXES-1:0] axisGrouped,
    input  wire eqsr_pkg::eqsr_posvec_t        actualPos,
    input  wire logic                  shortQueryTimeout,
    input  wire logic                  extErrValid,
    input  wire logic [9:0]            extErrCode
);
    import eqsr_pkg::*;

    function automatic logic [9:0] axisErr(input logic [3:0] axis, input logic [6:0] sfx);
        axisErr = 10'(axis * 100) + 10'(sfx);
    endfunction : axisErr

    function automatic logic [3:0] ringPrev(input logic [3:0] p);
        ringPrev = (p == 4'h0) ? 4'(QUEUE_DEPTH - 1) : p - 4'h1;
    endfunction : ringPrev

    function automatic logic [3:0] ringNext(input logic [3:0] p);
        ringNext = (p == 4'(QUEUE_DEPTH - 1)) ? 4'h0 : p + 4'h1;
    endfunction : ringNext

    // Bus state.
    logic        awHeld_r;
    logic        wHeld_r;
    logic [7:0]  awAddr_r;
    logic [31:0] wData_r;
    logic [3:0]  wStrb_r;

    // Block state.
    logic [31:0] tickDiv_r;
    logic [31:0] stamp_r;
    eqsr_entry_t queue_r [QUEUE_DEPTH];
    logic [3:0]  wrPtr_r;
    logic [3:0]  count_r;
    logic [2:0]  mode_r [NUM_AXES];
    logic [4:0]  scale_r;
    logic [9:0]  replyCode_r;
    logic [31:0] replyStamp_r;
    logic [9:0]  replyText_r;
    logic [31:0] replyData_r;
    logic [1:0]  replyChars_r;
    logic [2:0]  lastOp_r;
    logic        pendTimeout_r;
    logic        pendExt_r;
    logic [9:0]  pendExtCode_r;

    // Write commit decoding.
    wire         commit    = awHeld_r & wHeld_r & ~s_axi_bvalid;
    wire         wrMapped  = (awAddr_r <= REG_SCALE) && (awAddr_r[1:0] == 2'b00);
    wire         cmdWrite  = commit && (awAddr_r == REG_CMD) && (wStrb_r[1:0] == 2'b11);
    wire         scaleWrite = commit && (awAddr_r == REG_SCALE) && wStrb_r[0];
    eqsr_cmd_t   cmd;
    assign cmd = eqsr_cmd_t'(wData_r);

    wire         isMsgQuery  = cmdWrite && (cmd.opcode == OP_READ_ERROR_MESSAGE);
    wire         isCodeQuery = cmdWrite && (cmd.opcode == OP_READ_ERROR_CODE);
    wire         isTraj      = cmdWrite && (cmd.opcode == OP_SET_TRAJECTORY);
    wire         isPos       = cmdWrite && (cmd.opcode == OP_READ_POSITION);
    wire         isStatus    = cmdWrite && (cmd.opcode == OP_READ_STATUS);
    wire         isAxisCmd   = isTraj | isPos;
    wire         axisBad     = (cmd.axis == 4'h0) || (cmd.axis > 4'(NUM_AXES));
    wire [2:0]   axIdx       = 3'(cmd.axis - 4'h1);
    wire [2:0]   modeVal     = cmd.value[2:0];
    wire         modeBad     = (cmd.value == 4'h0) || (cmd.value > 4'(MODE_MAX));

    // Command error detection.
    logic [9:0]  cmdErrCode;
    logic        cmdErr;
    always_comb begin
        cmdErr     = 1'b0;
        cmdErrCode = ERR_NONE;
        if (isAxisCmd) begin
            if (!cmd.axisPresent) begin
                cmdErr     = 1'b1;
                cmdErrCode = ERR_AXIS_MISS;
            end else if (axisBad) begin
                cmdErr     = 1'b1;
                cmdErrCode = ERR_AXIS_RANGE;
            end else if (isTraj && !cmd.query) begin
                if (!cmd.valuePresent) begin
                    cmdErr     = 1'b1;
                    cmdErrCode = ERR_PARAM_MISS;
                end else if (modeBad) begin
                    cmdErr     = 1'b1;
                    cmdErrCode = axisErr(cmd.axis, SFX_PARAM_RANGE);
                end else if (axisMoving[axIdx]) begin
                    cmdErr     = 1'b1;
                    cmdErrCode = axisErr(cmd.axis, SFX_MOVING);
                end else if (axisGrouped[axIdx]) begin
                    cmdErr     = 1'b1;
                    cmdErrCode = axisErr(cmd.axis, SFX_GROUPED);
                end
            end
        end
    end

    wire         modeWrite = isTraj && !cmd.query && !cmdErr;

    // Push arbitration: a command error goes first, latched link events follow.
    wire         timeoutSeen = pendTimeout_r | shortQueryTimeout;
    wire         extSeen     = pendExt_r | extErrValid;
    wire [9:0]   extCodeSeen = extErrValid ? extErrCode : pendExtCode_r;
    wire         push        = cmdErr | timeoutSeen | extSeen;
    wire         pushTimeout = ~cmdErr & timeoutSeen;
    wire         pushExt     = ~cmdErr & ~timeoutSeen & extSeen;
    wire [9:0]   pushCode    = cmdErr ? cmdErrCode : (pushTimeout ? ERR_TIMEOUT : extCodeSeen);
    wire         pop         = (isMsgQuery | isCodeQuery) && (count_r != 4'h0);
    wire [3:0]   newestIdx   = ringPrev(wrPtr_r);
    eqsr_entry_t newest;
    assign newest = queue_r[newestIdx];

    // With a pop and a push together the fresh error takes the slot just vacated.
    wire [3:0]   pushIdx   = pop ? newestIdx : wrPtr_r;
    wire [3:0]   wrPtrNxt  = pop ? (push ? wrPtr_r : newestIdx) : (push ? ringNext(wrPtr_r) : wrPtr_r);
    wire [3:0]   countNxt  = pop ? (push ? count_r : count_r - 4'h1) :
                             (push && count_r != 4'(QUEUE_DEPTH)) ? count_r + 4'h1 : count_r;

    // Status characters.
    wire         anyPower  = |axisPowered;
    wire [7:0]   statChar0 = {STAT_FIXED, anyPower, axisMoving[3:0]};
    wire [7:0]   statChar1 = {STAT_FIXED, anyPower, 2'b00, axisMoving[5:4]};
    wire [31:0]  scaledPos = 32'($signed(actualPos[axIdx]) >>> scale_r);

    // Read data selection.
    logic [31:0] rdMux;
    logic        rdOk;
    always_comb begin
        rdOk  = 1'b1;
        rdMux = 32'h0000_0000;
        unique case (s_axi_araddr)
            REG_CMD:    rdMux = 32'h0000_0000;
            REG_RCODE:  rdMux = {22'h000000, replyCode_r};
            REG_RSTAMP: rdMux = replyStamp_r;
            REG_RTEXT:  rdMux = {22'h000000, replyText_r};
            REG_RDATA:  rdMux = replyData_r;
            REG_RINFO:  rdMux = {23'h000000, lastOp_r, replyChars_r, count_r};
            REG_SCALE:  rdMux = {27'h0000000, scale_r};
            default:    rdOk  = 1'b0;
        endcase
    end

    // AXI write channels.
    wire         awTake = s_axi_awvalid & s_axi_awready;
    wire         wTake  = s_axi_wvalid & s_axi_wready;
    wire         awHeldNxt = commit ? 1'b0 : (awHeld_r | awTake);
    wire         wHeldNxt  = commit ? 1'b0 : (wHeld_r | wTake);
    wire         bvalidNxt = commit | (s_axi_bvalid & ~s_axi_bready);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            awHeld_r      <= 1'b0;
            wHeld_r       <= 1'b0;
            awAddr_r      <= 8'h00;
            wData_r       <= 32'h0000_0000;
            wStrb_r       <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
        end else begin
            awHeld_r      <= awHeldNxt;
            wHeld_r       <= wHeldNxt;
            s_axi_awready <= ~awHeldNxt & ~bvalidNxt;
            s_axi_wready  <= ~wHeldNxt & ~bvalidNxt;
            s_axi_bvalid  <= bvalidNxt;
            if (awTake) begin
                awAddr_r <= s_axi_awaddr;
            end
            if (wTake) begin
                wData_r <= s_axi_wdata;
                wStrb_r <= s_axi_wstrb;
            end
            if (commit) begin
                s_axi_bresp <= wrMapped ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // AXI read channels.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rdMux;
            s_axi_rresp   <= rdOk ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end else begin
            s_axi_arready <= ~s_axi_rvalid;
        end
    end

    // Servo tick timestamp; a 32-bit count wraps after about 20 days of uptime.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            tickDiv_r <= 32'h0000_0000;
            stamp_r   <= 32'h0000_0000;
        end else if (tickDiv_r == 32'(TICK_LEN - 1)) begin
            tickDiv_r <= 32'h0000_0000;
            stamp_r   <= stamp_r + 32'h0000_0001;
        end else begin
            tickDiv_r <= tickDiv_r + 32'h0000_0001;
        end
    end

    // Latched link events, a new timeout wins over the clear of the same cycle, a new external error replaces the latched one in the push.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pendTimeout_r <= 1'b0;
            pendExt_r     <= 1'b0;
            pendExtCode_r <= ERR_NONE;
        end else begin
            pendTimeout_r <= shortQueryTimeout | (pendTimeout_r & ~pushTimeout);
            if (extErrValid && pendExt_r && !pushExt) begin
                pendExt_r <= 1'b1;
            end else begin
                pendExt_r <= extSeen & ~pushExt;
            end
            if (extErrValid && !(pendExt_r && !pushExt)) begin
                pendExtCode_r <= extErrCode;
            end
        end
    end

    // Error queue storage, a ring where the oldest slot is overwritten when full.
    genvar gi;
    generate
        for (gi = 0; gi < QUEUE_DEPTH; gi++) begin : gQueue
            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    queue_r[gi] <= '0;
                end else if (push && pushIdx == 4'(gi)) begin
                    queue_r[gi] <= '{code: pushCode, stamp: stamp_r};
                end
            end
        end
        for (gi = 0; gi < NUM_AXES; gi++) begin : gMode
            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    mode_r[gi] <= MODE_TRAPEZOID;
                end else if (modeWrite && axIdx == 3'(gi)) begin
                    mode_r[gi] <= modeVal;
                end
            end
        end
    endgenerate

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wrPtr_r <= 4'h0;
            count_r <= 4'h0;
            scale_r <= SCALE_RESET;
        end else begin
            wrPtr_r <= wrPtrNxt;
            count_r <= countNxt;
            if (scaleWrite) begin
                scale_r <= wData_r[4:0];
            end
        end
    end

    // Reply registers, refreshed by each command.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            replyCode_r  <= ERR_NONE;
            replyStamp_r <= 32'h0000_0000;
            replyText_r  <= ERR_NONE;
            replyData_r  <= 32'h0000_0000;
            replyChars_r <= 2'h0;
            lastOp_r     <= 3'h0;
        end else if (cmdWrite) begin
            lastOp_r     <= cmd.opcode;
            replyChars_r <= 2'h0;
            replyData_r  <= 32'h0000_0000;
            replyStamp_r <= 32'h0000_0000;
            replyText_r  <= ERR_NONE;
            replyCode_r  <= ERR_NONE;
            if (isMsgQuery) begin
                // Code, then timestamp, then text id; text id 0 is the no-error text.
                replyCode_r  <= pop ? newest.code : ERR_NONE;
                replyStamp_r <= pop ? newest.stamp : stamp_r;
                replyText_r  <= pop ? newest.code : ERR_NONE;
            end else if (isCodeQuery) begin
                replyCode_r  <= pop ? newest.code : ERR_NONE;
            end else if (isTraj && cmd.query && !cmdErr) begin
                replyData_r  <= {29'h00000000, mode_r[axIdx]};
            end else if (isPos && !cmdErr) begin
                replyData_r  <= scaledPos;
            end else if (isStatus) begin
                replyData_r  <= {16'h0000, statChar0, statChar1};
                replyChars_r <= (NUM_AXES > 4) ? 2'h2 : 2'h1;
            end
        end
    end
endmodule : eqsr_top

// >>> verilog/eqsr_pkg.sv
// Constants and types for the error queue and status reporter.
// Assumes a 50 MHz system clock and an AXI4-Lite master with 32-bit data.
package eqsr_pkg;
    localparam int          NUM_AXES       = 6;
    localparam int          QUEUE_DEPTH    = 10;
    localparam int          CLK_PERIOD_NS  = 20;
    localparam int          SERVO_TICK_US  = 400;
    localparam int          TICK_CYCLES    = (SERVO_TICK_US * 1000) / CLK_PERIOD_NS;

    // Register byte offsets.
    localparam logic [7:0]  REG_CMD        = 8'h00;
    localparam logic [7:0]  REG_RCODE      = 8'h04;
    localparam logic [7:0]  REG_RSTAMP     = 8'h08;
    localparam logic [7:0]  REG_RTEXT      = 8'h0C;
    localparam logic [7:0]  REG_RDATA      = 8'h10;
    localparam logic [7:0]  REG_RINFO      = 8'h14;
    localparam logic [7:0]  REG_SCALE      = 8'h18;

    // Command opcodes.
    localparam logic [2:0]  OP_READ_ERROR_MESSAGE = 3'h1;
    localparam logic [2:0]  OP_READ_ERROR_CODE    = 3'h2;
    localparam logic [2:0]  OP_SET_TRAJECTORY     = 3'h3;
    localparam logic [2:0]  OP_READ_POSITION      = 3'h4;
    localparam logic [2:0]  OP_READ_STATUS        = 3'h5;

    // Error codes and suffixes.
    localparam logic [9:0]  ERR_NONE       = 10'h000;
    localparam logic [9:0]  ERR_TIMEOUT    = 10'h002;
    localparam logic [9:0]  ERR_AXIS_RANGE = 10'h009;
    localparam logic [9:0]  ERR_AXIS_MISS  = 10'h025;
    localparam logic [9:0]  ERR_PARAM_MISS = 10'h026;
    localparam logic [6:0]  SFX_PARAM_RANGE = 7'h02;
    localparam logic [6:0]  SFX_MOVING      = 7'h1A;
    localparam logic [6:0]  SFX_GROUPED     = 7'h1F;

    // Trajectory modes.
    localparam logic [2:0]  MODE_TRAPEZOID = 3'h1;
    localparam logic [2:0]  MODE_MAX       = 3'h6;

    // Status character fixed bits 7..5.
    localparam logic [2:0]  STAT_FIXED     = 3'h2;

    localparam logic [4:0]  SCALE_RESET    = 5'h00;
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;

    typedef struct packed {
        logic [9:0]  code;
        logic [31:0] stamp;
    } eqsr_entry_t;

    // Layout of a word written to the command register.
    typedef struct packed {
        logic [17:0] unused;
        logic        query;
        logic        valuePresent;
        logic [3:0]  value;
        logic        axisPresent;
        logic [3:0]  axis;
        logic [2:0]  opcode;
    } eqsr_cmd_t;

    typedef logic [NUM_AXES-1:0][31:0] eqsr_posvec_t;
endpackage : eqsr_pkg

// >>> bench/eqsr_top_monitor.sv
// Bus timing checker for the error queue and status reporter.
// Assumes one clock and a synchronous active-high reset; bound to eqsr_top.
`timescale 1ns/1ns
module eqsr_top_monitor
    import eqsr_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic [7:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    wire badWr = (s_axi_awaddr[1:0] != 2'h0) || (s_axi_awaddr > REG_SCALE);
    wire badRd = (s_axi_araddr[1:0] != 2'h0) || (s_axi_araddr > REG_SCALE);
    sequence wrTaken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rdTaken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    wr_answer_due_a: assert property (wrTaken |-> ##2 s_axi_bvalid)
        else $error("write response not on time");
    wr_bad_addr_a: assert property (wrTaken ##0 badWr |-> ##2 s_axi_bresp == RESP_SLVERR)
        else $error("unmapped write not refused");
    b_one_beat_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    ready_back_a: assert property (s_axi_bvalid && s_axi_bready |=> s_axi_awready && s_axi_wready)
        else $error("write channels not reopened");
    aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    rd_answer_a: assert property (rdTaken |=> s_axi_rvalid)
        else $error("read data not on time");
    rd_bad_addr_a: assert property (rdTaken ##0 badRd |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    rd_okay_a: assert property (rdTaken ##0 !badRd |=> s_axi_rresp == RESP_OKAY)
        else $error("mapped read refused");
    ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while data pending");
endmodule : eqsr_top_monitor

bind eqsr_top eqsr_top_monitor eqsr_top_monitor_i (.sys_clk, .rst, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);

// >>> bench/eqsr_host.sv
// Host model: an AXI4-Lite master through which software issues commands.
// Assumes its tasks are called just after a rising edge of sys_clk.
`timescale 1ns/1ns
module eqsr_host (
    input  wire logic        sys_clk,
    output logic [7:0]       s_axi_awaddr,
    output logic             s_axi_awvalid,
    input  wire logic        s_axi_awready,
    output logic [31:0]      s_axi_wdata,
    output logic [3:0]       s_axi_wstrb,
    output logic             s_axi_wvalid,
    input  wire logic        s_axi_wready,
    input  wire logic [1:0]  s_axi_bresp,
    input  wire logic        s_axi_bvalid,
    output logic             s_axi_bready,
    output logic [7:0]       s_axi_araddr,
    output logic             s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic [1:0]  s_axi_rresp,
    input  wire logic        s_axi_rvalid,
    output logic             s_axi_rready,
    output logic             hung
);
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_araddr, s_axi_arvalid, s_axi_rready, hung} = '0;
    end
    // Illegal modes and changes on moving axes go out only when a scenario wants them.
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
        int n;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hF;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid && n < 200);
        s_axi_bready <= 1'b0;
        resp = s_axi_bresp;
        if (n >= 200) hung = 1'b1;
        @(posedge sys_clk);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
        int n;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid && n < 200);
        s_axi_rready <= 1'b0;
        d = s_axi_rdata;
        resp = s_axi_rresp;
        if (n >= 200) hung = 1'b1;
        @(posedge sys_clk);
    endtask : rd
endmodule : eqsr_host

// >>> bench/tb.sv
// Self-checking bench for the error queue and status reporter.
// Assumes the host model and checker files are compiled before this one.
`timescale 1ns/1ns
module tb;
    import eqsr_pkg::*;
    localparam int TL = 4;
    logic sys_clk, rst, shortQueryTimeout, extErrValid;
    logic [5:0] axisMoving, axisPowered, axisGrouped;
    logic [9:0] extErrCode;
    eqsr_posvec_t actualPos;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, hung;
    int n_errors = 0;
    int n_checks = 0;
    eqsr_top #(.TICK_LEN(TL)) eqsr_top_i (.sys_clk, .rst, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .axisMoving, .axisPowered,
        .axisGrouped, .actualPos, .shortQueryTimeout, .extErrValid, .extErrCode);
    eqsr_host eqsr_host_i (.sys_clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .hung);
    always #10 sys_clk = ~sys_clk;
    task automatic results();
        if (n_errors == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : results
    // A stuck handshake ends the run here rather than hanging it.
    always @(posedge sys_clk) begin
        if (hung) begin
            n_errors++;
            results();
        end
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic cmd(input logic [2:0] op, input logic [4:0] ax, input logic [4:0] v, input logic q);
        eqsr_cmd_t c;
        logic [1:0] r;
        c = '0;
        c.opcode = op;
        c.axis = ax[3:0];
        c.axisPresent = ax[4];
        c.value = v[3:0];
        c.valuePresent = v[4];
        c.query = q;
        eqsr_host_i.wr(REG_CMD, c, r);
    endtask : cmd
    task automatic rdw(input logic [7:0] a, output logic [31:0] d);
        logic [1:0] r;
        eqsr_host_i.rd(a, d, r);
    endtask : rdw
    task automatic sc_traj();
        logic [31:0] d;
        logic [4:0] axT [6] = '{5'h02, 5'h17, 5'h12, 5'h12, 5'h13, 5'h14};
        logic [4:0] vaT [6] = '{5'h11, 5'h11, 5'h00, 5'h17, 5'h12, 5'h12};
        logic [9:0] exT [6] = '{10'h025, 10'h009, 10'h026, 10'h0CA, 10'h146, 10'h1AF};
        cmd(OP_SET_TRAJECTORY, 5'h11, 5'h00, 1'b1);
        rdw(REG_RDATA, d);
        chk("reset mode", 32'h1, d);
        for (int m = 1; m <= 6; m++) begin
            cmd(OP_SET_TRAJECTORY, 5'h12, 5'h10 | 5'(m), 1'b0);
            cmd(OP_SET_TRAJECTORY, 5'h12, 5'h00, 1'b1);
            rdw(REG_RDATA, d);
            chk("mode", 32'(m), d);
        end
        axisMoving <= 6'h04;
        axisGrouped <= 6'h08;
        for (int i = 0; i < 6; i++) cmd(OP_SET_TRAJECTORY, axT[i], vaT[i], 1'b0);
        axisMoving <= 6'h00;
        axisGrouped <= 6'h00;
        cmd(OP_SET_TRAJECTORY, 5'h13, 5'h00, 1'b1);
        rdw(REG_RDATA, d);
        chk("mode kept", 32'h1, d);
        for (int i = 5; i >= 0; i--) begin
            cmd(OP_READ_ERROR_CODE, 5'h00, 5'h00, 1'b1);
            rdw(REG_RCODE, d);
            chk("error code", 32'(exT[i]), d);
        end
    endtask : sc_traj
    task automatic sc_queue();
        logic [31:0] d, s9, s10;
        cmd(OP_READ_ERROR_MESSAGE, 5'h00, 5'h00, 1'b1);
        rdw(REG_RTEXT, d);
        chk("empty text", 32'h0, d);
        extErrValid <= 1'b1;
        for (int i = 0; i < 10; i++) begin
            extErrCode <= 10'h032 + 10'(i);
            @(posedge sys_clk);
        end
        // The last two errors are spaced eight ticks apart to expose the stamp rate.
        for (int i = 10; i < 12; i++) begin
            extErrValid <= 1'b0;
            repeat (8 * TL - 1) @(posedge sys_clk);
            extErrValid <= 1'b1;
            extErrCode <= 10'h032 + 10'(i);
            @(posedge sys_clk);
        end
        extErrValid <= 1'b0;
        rdw(REG_RINFO, d);
        chk("queue count", 32'hA, {28'h0, d[3:0]});
        cmd(OP_READ_ERROR_CODE, 5'h00, 5'h00, 1'b1);
        rdw(REG_RCODE, d);
        chk("newest code", 32'h3D, d);
        rdw(REG_RSTAMP, d);
        chk("code query stamp", 32'h0, d);
        cmd(OP_READ_ERROR_MESSAGE, 5'h00, 5'h00, 1'b1);
        rdw(REG_RCODE, d);
        chk("message code", 32'h3C, d);
        rdw(REG_RTEXT, d);
        chk("message text", 32'h3C, d);
        rdw(REG_RSTAMP, s10);
        cmd(OP_READ_ERROR_MESSAGE, 5'h00, 5'h00, 1'b1);
        rdw(REG_RSTAMP, s9);
        chk("stamp step", 32'h8, s10 - s9);
        for (int i = 8; i >= 1; i--) begin
            cmd(OP_READ_ERROR_CODE, 5'h00, 5'h00, 1'b1);
            rdw(REG_RCODE, d);
            chk("queue order", (i < 2) ? 32'h0 : 32'h32 + 32'(i), d);
        end
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        cmd(OP_READ_ERROR_MESSAGE, 5'h00, 5'h00, 1'b1);
        rdw(REG_RSTAMP, d);
        chk("stamp cleared", 32'h1, {31'h0, d < 32'h8});
    endtask : sc_queue
    task automatic sc_status();
        logic [31:0] d;
        axisMoving <= 6'h2B;
        axisPowered <= 6'h04;
        cmd(OP_READ_STATUS, 5'h00, 5'h00, 1'b0);
        rdw(REG_RDATA, d);
        chk("status moving", 32'h5B52, d);
        rdw(REG_RINFO, d);
        chk("status chars", 32'h2, {30'h0, d[5:4]});
        axisMoving <= 6'h14;
        axisPowered <= 6'h00;
        cmd(OP_READ_STATUS, 5'h00, 5'h00, 1'b0);
        rdw(REG_RDATA, d);
        chk("status unpowered", 32'h4441, d);
    endtask : sc_status
    task automatic sc_bus();
        logic [31:0] d;
        logic [1:0] r;
        actualPos[2] <= 32'hFFFFFFC0;
        eqsr_host_i.wr(REG_SCALE, 32'h2, r);
        rdw(REG_SCALE, d);
        chk("scale", 32'h2, d);
        cmd(OP_READ_POSITION, 5'h13, 5'h00, 1'b0);
        rdw(REG_RDATA, d);
        chk("position", 32'hFFFFFFF0, d);
        eqsr_host_i.rd(8'h1C, d, r);
        chk("unmapped read", {30'h0, RESP_SLVERR}, {30'h0, r});
        eqsr_host_i.wr(8'h1C, 32'h1, r);
        chk("unmapped write", {30'h0, RESP_SLVERR}, {30'h0, r});
        eqsr_host_i.rd(8'h02, d, r);
        chk("unaligned read", {30'h0, RESP_SLVERR}, {30'h0, r});
        shortQueryTimeout <= 1'b1;
        @(posedge sys_clk);
        shortQueryTimeout <= 1'b0;
        cmd(OP_READ_ERROR_CODE, 5'h00, 5'h00, 1'b1);
        rdw(REG_RCODE, d);
        chk("timeout code", 32'h2, d);
    endtask : sc_bus
    initial begin
        sys_clk = 1'b0;
        rst = 1'b1;
        {axisMoving, axisPowered, axisGrouped, extErrCode} = '0;
        {shortQueryTimeout, extErrValid} = '0;
        actualPos = '0;
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        sc_traj();
        sc_queue();
        sc_status();
        sc_bus();
        results();
    end
endmodule : tb
